// ### core/acl_match_table.sv
// match table: 32 rule entries, parallel compare, ordered hit walk
// assumes same-clock parser and result stage, AXI4-Lite from software
`default_nettype none

// Overview of operation
// - every ingress packet offered is compared against the table
// - each field has an enable or a mask; disabled fields do not affect hit
// - sense bit 1 means equal hits, 0 means unequal; senses reset 1
// - each hit index is handed to the result stage for its actions
// - actions of all hitting entries are carried out, not one winner
// - hits are handed over in ascending index order from entry zero
// - 32 entries of 16 words each, readable and writable by software
// - all entries compared at once in the cycle a packet is taken
// - source address in bits 127:0; IPv4 uses low 32 bits only
// - destination in 255:128; IPv4 low 32 bits, MPLS low 20 bits
// - nine-bit flag mask selects which packet flags must match
// - flag value bit 8 is NS down to bit 0 FIN
// - first options byte compared under an eight-bit mask
// - source address enabled by bit 290, sense bit 291
// - destination enabled by bit 292, sense bit 293
// - chain tag test enabled by 294, sense 295, value 296
// - transport source port compared when 297 set, sense 298
// - transport destination port compared when 315 set, sense 316
// - service type byte compared when 333 set, sense 334
// - payload type compared when 343 set, sense 344
// - IPv4 indication compared only when bit 353 is set
// - twelve-bit port mask selects the ingress ports a rule covers
// - a hit with discard action drops packet, bumps drop counter
module acl_match_table (
	input  wire logic                           clock,
	input  wire logic                           srst,
	input  wire logic                           ce,
	input  wire logic [acl_match_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output logic                                wready,
	output logic [1:0]                          bresp,
	output logic                                bvalid,
	input  wire logic                           bready,
	input  wire logic [acl_match_pkg::ADDR_W-1:0] araddr,
	input  wire logic                           arvalid,
	output logic                                arready,
	output logic [31:0]                         rdata,
	output logic [1:0]                          rresp,
	output logic                                rvalid,
	input  wire logic                           rready,
	input  wire logic                           pkt_valid,
	output logic                                pkt_ready,
	input  wire logic [127:0]                   pkt_src_ip,
	input  wire logic [127:0]                   pkt_dst_ip,
	input  wire logic                           pkt_is_ipv4,
	input  wire logic                           pkt_is_mpls,
	input  wire logic [8:0]                     pkt_tcp_flags,
	input  wire logic [7:0]                     pkt_options_byte,
	input  wire logic                           pkt_chain_present,
	input  wire logic [15:0]                    pkt_src_l4_port,
	input  wire logic [15:0]                    pkt_dst_l4_port,
	input  wire logic [7:0]                     pkt_service_type,
	input  wire logic [7:0]                     pkt_payload_type,
	input  wire logic [3:0]                     pkt_ingress_port,
	output logic                                act_valid,
	output logic [4:0]                          act_index,
	input  wire logic                           act_ready,
	input  wire logic                           act_discard,
	output logic                                pkt_done,
	output logic                                pkt_discard,
	output logic [31:0]                         drop_count
);
	import acl_match_pkg::*;

	// ********************************************************
	// helper functions
	// ********************************************************
	// one field under its enable and sense
	function automatic logic sensed(input logic en, input logic sense,
		input logic eq);
		return !en || (sense ? eq : !eq);
	endfunction : sensed
	// lowest set bit, so the walk starts at entry zero
	function automatic logic [4:0] lowest(input logic [31:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = ENTRY_COUNT - 1; i >= 0; i--)
			idx = v[i] ? i[4:0] : idx;
		return idx;
	endfunction : lowest
	// byte-lane merge for a register write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			r[b*8 +: 8] = s[b] ? d[b*8 +: 8] : r[b*8 +: 8];
		return r;
	endfunction : merge
	// word index inside the rule table, and the word's slot there
	function automatic logic in_table(input logic [IDX_W-1:0] idx);
		return idx >= TABLE_BASE_IDX && idx <= TABLE_LAST_IDX;
	endfunction : in_table
	function automatic logic [8:0] table_slot(input logic [IDX_W-1:0] idx);
		return 9'(idx - TABLE_BASE_IDX);
	endfunction : table_slot

	// whole-entry decision against the packet now offered
	function automatic logic entry_hit(input logic [ENTRY_BITS-1:0] e,
		input logic [127:0] sip, input logic [127:0] dip,
		input logic v4, input logic mpls, input logic [8:0] fl,
		input logic [7:0] opt, input logic ch, input logic [15:0] sp,
		input logic [15:0] dp, input logic [7:0] tos,
		input logic [7:0] pt, input logic [3:0] port);
		logic sip_eq;
		logic dip_eq;
		logic [11:0] members;
		logic ok;
		// IPv4 looks at the low word only
		sip_eq = v4 ? (e[SIP_LSB +: IPV4_BITS] == sip[IPV4_BITS-1:0])
			: (e[SIP_LSB +: 128] == sip);
		// MPLS label compares only twenty bits
		dip_eq = v4 ? (e[DIP_LSB +: IPV4_BITS] == dip[IPV4_BITS-1:0])
			: mpls ? (e[DIP_LSB +: MPLS_BITS] == dip[MPLS_BITS-1:0])
			: (e[DIP_LSB +: 128] == dip);
		members = e[PORTS_LSB +: PORT_COUNT];
		ok = sensed(e[SIP_EN], e[SIP_SENSE], sip_eq);
		ok = ok && sensed(e[DIP_EN], e[DIP_SENSE], dip_eq);
		// stored flags are NS at bit 8 down to FIN at bit 0
		ok = ok && (((e[TCP_VALUE_LSB +: 9] ^ fl)
			& e[TCP_MASK_LSB +: 9]) == 9'h000);
		ok = ok && (((e[OPT_VALUE_LSB +: 8] ^ opt)
			& e[OPT_MASK_LSB +: 8]) == 8'h00);
		ok = ok && sensed(e[CHAIN_EN], e[CHAIN_SENSE],
			e[CHAIN_VALUE] == ch);
		ok = ok && sensed(e[SPORT_EN], e[SPORT_SENSE],
			e[SPORT_LSB +: 16] == sp);
		ok = ok && sensed(e[DPORT_EN], e[DPORT_SENSE],
			e[DPORT_LSB +: 16] == dp);
		ok = ok && sensed(e[TOS_EN], e[TOS_SENSE],
			e[TOS_LSB +: 8] == tos);
		ok = ok && sensed(e[PTYPE_EN], e[PTYPE_SENSE],
			e[PTYPE_LSB +: 8] == pt);
		ok = ok && sensed(e[IPV4_EN], e[IPV4_SENSE],
			e[IPV4_VALUE] == v4);
		// ports beyond the twelfth belong to no rule
		ok = ok && (port < PORT_COUNT) && members[port];
		return ok;
	endfunction : entry_hit

	// ********************************************************
	// storage and state
	// ********************************************************
	logic [31:0]       table_r [0:TABLE_WORDS-1];
	logic              aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic [IDX_W-1:0]  aw_idx_r;
	logic [31:0]       wdata_r, rdata_r, pending_r, last_hits_r;
	logic [3:0]        wstrb_r;
	logic [1:0]        bresp_r, rresp_r;
	walk_state_t       state_r;
	logic [4:0]        act_index_r;
	logic              discard_acc_r, pkt_done_r, pkt_discard_r;
	logic [31:0]       drop_count_r, hit_now;
	// ********************************************************
	// bus decode
	// ********************************************************
	wire [IDX_W-1:0] ar_idx     = araddr[ADDR_W-1:2];
	wire             wr_do      = aw_held_r && w_held_r && !bvalid_r;
	wire             wr_table   = wr_do && in_table(aw_idx_r);
	wire             wr_drop    = wr_do && aw_idx_r == DROP_COUNT_IDX;
	wire             wr_known   = in_table(aw_idx_r) || wr_drop
		|| aw_idx_r == LAST_HITS_IDX;
	wire [8:0]       wr_slot    = table_slot(aw_idx_r);
	wire [8:0]       rd_slot    = table_slot(ar_idx);
	wire             rd_fire    = arvalid && !rvalid_r;
	wire             rd_table   = in_table(ar_idx);
	wire             rd_known   = rd_table || ar_idx == DROP_COUNT_IDX
		|| ar_idx == LAST_HITS_IDX;
	wire [31:0]      rd_word    = rd_table ? table_r[rd_slot]
		: ar_idx == DROP_COUNT_IDX ? drop_count_r
		: ar_idx == LAST_HITS_IDX ? last_hits_r : 32'h0000_0000;
	// readies drop while frozen, else a beat taken then would be lost
	assign awready = ce && !aw_held_r;
	assign wready  = ce && !w_held_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = ce && !rvalid_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// ********************************************************
	// write channel: address and data taken in either order
	// ********************************************************
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			aw_held_r <= 1'b0;
			aw_idx_r  <= '0;
			w_held_r  <= 1'b0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (awvalid && !aw_held_r)
			begin
				aw_held_r <= 1'b1;
				aw_idx_r  <= awaddr[ADDR_W-1:2];
			end
			if (wvalid && !w_held_r)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
			end
			if (wr_do)
			begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_r && bready)
				bvalid_r <= 1'b0;
		end
	end

	// read channel: one cycle from address to data
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (rd_fire)
			begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_word;
				rresp_r  <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_r && rready)
				rvalid_r <= 1'b0;
		end
	end

	// table words; bits above the entry width stay zero
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			for (int i = 0; i < TABLE_WORDS; i++)
				table_r[i] <= ENTRY_RESET[(i % WORDS_PER_ENTRY) * 32 +: 32];
		end
		else if (ce && wr_table)
			table_r[wr_slot] <= merge(table_r[wr_slot], wdata_r, wstrb_r)
				& ENTRY_USED[wr_slot[3:0] * 32 +: 32];
	end

	// ********************************************************
	// parallel compare of all entries
	// ********************************************************
	// every entry is evaluated combinationally; area traded for speed
	for (genvar e = 0; e < ENTRY_COUNT; e++)
	begin : g_entry
		logic [FLAT_BITS-1:0] flat;
		for (genvar w = 0; w < WORDS_PER_ENTRY; w++)
		begin : g_word
			assign flat[w*32 +: 32] = table_r[e*WORDS_PER_ENTRY + w];
		end
		assign hit_now[e] = entry_hit(flat[ENTRY_BITS-1:0], pkt_src_ip,
			pkt_dst_ip, pkt_is_ipv4, pkt_is_mpls, pkt_tcp_flags,
			pkt_options_byte, pkt_chain_present, pkt_src_l4_port,
			pkt_dst_l4_port, pkt_service_type, pkt_payload_type,
			pkt_ingress_port);
	end

	// ********************************************************
	// hit walk toward the result stage
	// ********************************************************
	wire        pkt_fire   = pkt_valid && pkt_ready;
	wire        act_fire   = act_valid && act_ready;
	wire [31:0] pend_after = pending_r & ~(32'h1 << act_index_r);
	assign pkt_ready   = ce && state_r == WALK_IDLE;
	assign act_valid   = ce && state_r == WALK_BUSY
		&& pending_r != 32'h0;
	assign act_index   = act_index_r;
	assign pkt_done    = pkt_done_r;
	assign pkt_discard = pkt_discard_r;
	assign drop_count  = drop_count_r;

	// a new packet waits until every hit of the last one is served
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_r       <= WALK_IDLE;
			pending_r     <= 32'h0000_0000;
			last_hits_r   <= 32'h0000_0000;
			act_index_r   <= 5'h00;
			discard_acc_r <= 1'b0;
			pkt_done_r    <= 1'b0;
			pkt_discard_r <= 1'b0;
		end
		else if (ce)
		begin
			pkt_done_r <= 1'b0;
			case (state_r)
				WALK_IDLE:
				begin
					if (pkt_fire)
					begin
						state_r       <= WALK_BUSY;
						pending_r     <= hit_now;
						last_hits_r   <= hit_now;
						act_index_r   <= lowest(hit_now);
						discard_acc_r <= 1'b0;
					end
				end
				WALK_BUSY:
				begin
					if (act_fire)
					begin
						pending_r     <= pend_after;
						act_index_r   <= lowest(pend_after);
						discard_acc_r <= discard_acc_r || act_discard;
					end
					else if (pending_r == 32'h0)
					begin
						state_r       <= WALK_IDLE;
						pkt_done_r    <= 1'b1;
						pkt_discard_r <= discard_acc_r;
					end
				end
				default:
					state_r <= WALK_IDLE;
			endcase
		end
	end

	// drop counter: write clears, a dropped packet in that cycle still counts
	wire drop_step = pkt_done_r && pkt_discard_r;
	always_ff @(posedge clock)
	begin
		if (srst)
			drop_count_r <= 32'h0000_0000;
		else if (ce)
			drop_count_r <= (wr_drop ? 32'h0000_0000 : drop_count_r)
				+ {31'h0, drop_step};
	end

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst || !ce);
	sequence s_taken;
		pkt_fire;
	endsequence
	sequence s_walk_started;
		state_r == WALK_BUSY && pending_r == $past(hit_now);
	endsequence
	a_hits_captured: assert property (s_taken |=> s_walk_started)
		else $error("hit vector not captured at packet take");
	a_packet_taken: assert property (pkt_valid
		&& state_r == WALK_IDLE |-> pkt_ready)
		else $error("idle table refused a packet");
	a_walk_ascending: assert property (act_valid
		|-> (pending_r & ((32'h1 << act_index) - 32'h1)) == 32'h0)
		else $error("lower hit index skipped");
	a_fetch_is_hit: assert property (act_valid
		|-> last_hits_r[act_index])
		else $error("handed index did not hit");
	a_each_hit_served: assert property (act_fire
		|=> !pending_r[$past(act_index)])
		else $error("served hit still pending");
	a_done_after_all: assert property (pkt_done
		|-> pending_r == 32'h0 && state_r == WALK_IDLE)
		else $error("packet finished with hits left");
	a_no_hit_no_drop: assert property (pkt_done
		&& last_hits_r == 32'h0 |-> !pkt_discard)
		else $error("packet dropped without any hit");
	a_drop_counted: assert property (pkt_done && pkt_discard
		&& !wr_drop |=> drop_count == $past(drop_count) + 32'h1)
		else $error("drop counter did not step");
	a_write_answered: assert property (wr_do
		|=> bvalid && (bresp == RESP_OKAY) == $past(wr_known))
		else $error("write response missing or wrong");
endmodule : acl_match_table

`default_nettype wire

// ### core/acl_match_pkg.sv
// package of constants for the layer-3/layer-4 access-control match table
// assumes a single clock domain and an AXI4-Lite register master
`default_nettype none

package acl_match_pkg;

	// ********************************************************
	// geometry of the rule table
	// ********************************************************
	localparam int ENTRY_COUNT     = 32;
	localparam int WORDS_PER_ENTRY = 16;
	localparam int ENTRY_BITS      = 389;
	localparam int FLAT_BITS       = 512;
	localparam int TABLE_WORDS     = 512;
	localparam int IDX_W           = 18;
	localparam int ADDR_W          = 20;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] TABLE_BASE_IDX = 18'h147FA;
	localparam logic [IDX_W-1:0] TABLE_LAST_IDX = 18'h149F9;
	localparam logic [IDX_W-1:0] DROP_COUNT_IDX = 18'h14A00;
	localparam logic [IDX_W-1:0] LAST_HITS_IDX  = 18'h14A01;

	// ********************************************************
	// field layout of one entry
	// ********************************************************
	localparam int SIP_LSB        = 0;
	localparam int DIP_LSB        = 128;
	localparam int TCP_MASK_LSB   = 256;
	localparam int TCP_VALUE_LSB  = 265;
	localparam int OPT_MASK_LSB   = 274;
	localparam int OPT_VALUE_LSB  = 282;
	localparam int SIP_EN         = 290;
	localparam int SIP_SENSE      = 291;
	localparam int DIP_EN         = 292;
	localparam int DIP_SENSE      = 293;
	localparam int CHAIN_EN       = 294;
	localparam int CHAIN_SENSE    = 295;
	localparam int CHAIN_VALUE    = 296;
	localparam int SPORT_EN       = 297;
	localparam int SPORT_SENSE    = 298;
	localparam int SPORT_LSB      = 299;
	localparam int DPORT_EN       = 315;
	localparam int DPORT_SENSE    = 316;
	localparam int DPORT_LSB      = 317;
	localparam int TOS_EN         = 333;
	localparam int TOS_SENSE      = 334;
	localparam int TOS_LSB        = 335;
	localparam int PTYPE_EN       = 343;
	localparam int PTYPE_SENSE    = 344;
	localparam int PTYPE_LSB      = 345;
	localparam int IPV4_EN        = 353;
	localparam int IPV4_SENSE     = 354;
	localparam int IPV4_VALUE     = 355;
	localparam int PORTS_LSB      = 377;
	localparam int PORT_COUNT     = 12;
	localparam int IPV4_BITS      = 32;
	localparam int MPLS_BITS      = 20;

	// sense bits reset to equal-as-hit, everything else to zero
	localparam logic [FLAT_BITS-1:0] ENTRY_RESET =
		(512'h1 << SIP_SENSE) | (512'h1 << DIP_SENSE) |
		(512'h1 << CHAIN_SENSE) | (512'h1 << SPORT_SENSE) |
		(512'h1 << DPORT_SENSE) | (512'h1 << TOS_SENSE) |
		(512'h1 << PTYPE_SENSE) | (512'h1 << IPV4_SENSE);
	localparam logic [FLAT_BITS-1:0] ENTRY_USED =
		(512'h1 << ENTRY_BITS) - 512'h1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {WALK_IDLE, WALK_BUSY} walk_state_t;

endpackage : acl_match_pkg

`default_nettype wire

// ### dv/acl_result_stage.sv
// result stage model: takes hit indices, answers with discard bits
// assumes the match table's clock; stalls at random like a busy stage
`default_nettype none

module acl_result_stage (
	input  wire logic        clock,
	input  wire logic        act_valid,
	input  wire logic [4:0]  act_index,
	input  wire logic [31:0] discard_map,
	output logic             act_ready,
	output logic             act_discard
);
	timeunit 1ns;
	timeprecision 1ns;

	int seed = 32'hD1C4;

	// ready in two cycles of three, also with nothing offered
	initial
	begin
		act_ready = 1'b0;
		forever @(posedge clock)
			act_ready <= ($random(seed) % 3) != 0;
	end

	// discard bit of the same-index result entry; junk when idle
	assign act_discard = act_valid ? discard_map[act_index]
		: !discard_map[act_index];

endmodule : acl_result_stage

`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the access-control match table
// assumes acl_result_stage on the action side, AXI4-Lite from software
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import acl_match_pkg::*;

	// ********
	// signals
	// ********
	logic               clock, srst, ce, awvalid, awready, wvalid, wready;
	logic               bvalid, bready, arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0]  awaddr, araddr;
	logic [31:0]        wdata, rdata, drop_count, dmap, lasthit;
	logic [3:0]         wstrb, pkt_ingress_port;
	logic [1:0]         bresp, rresp;
	logic               pkt_valid, pkt_ready, pkt_is_ipv4, pkt_is_mpls;
	logic               pkt_chain_present, act_valid, act_ready, act_discard;
	logic               pkt_done, pkt_discard;
	logic [4:0]         act_index;
	logic [127:0]       pkt_src_ip, pkt_dst_ip;
	logic [8:0]         pkt_tcp_flags;
	logic [7:0]         pkt_options_byte, pkt_service_type, pkt_payload_type;
	logic [15:0]        pkt_src_l4_port, pkt_dst_l4_port;
	logic [511:0]       ent [32];
	logic [511:0]       rv, keep;
	logic [63:0]        qb [$];
	logic [63:0]        qp [$];
	int                 seed = 32'hD1C4;
	int                 num_errors = 0;
	int                 tests_run = 0;
	int                 cyc = 0;
	int                 ndrop = 0;
	int                 sense_bits [8] = '{291, 293, 295, 298, 316, 334,
		344, 354};
	localparam logic [IDX_W-1:0] BASE = 18'h147FA; // word 0 of entry 0

	acl_match_table i_acl_match_table (.clock, .srst, .ce, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .pkt_valid, .pkt_ready, .pkt_src_ip, .pkt_dst_ip,
		.pkt_is_ipv4, .pkt_is_mpls, .pkt_tcp_flags, .pkt_options_byte,
		.pkt_chain_present, .pkt_src_l4_port, .pkt_dst_l4_port,
		.pkt_service_type, .pkt_payload_type, .pkt_ingress_port, .act_valid,
		.act_index, .act_ready, .act_discard, .pkt_done, .pkt_discard,
		.drop_count);
	acl_result_stage i_acl_result_stage (.clock, .act_valid, .act_index,
		.discard_map(dmap), .act_ready, .act_discard);

	// ********
	// helpers
	// ********
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// an empty queue yields a value no real result can carry
	function automatic logic [63:0] pop(ref logic [63:0] q[$]);
		if (q.size() == 0)
			return '1;
		return q.pop_front();
	endfunction : pop

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// field passes when disabled, else when equality meets the sense bit
	function automatic logic fh(input logic [511:0] x, input logic eq,
		input int en);
		return !x[en] || eq == x[en + 1];
	endfunction : fh

	function automatic logic hit(input logic [511:0] x);
		logic [127:0] ms;
		logic [127:0] md;
		ms = pkt_is_ipv4 ? 128'hFFFF_FFFF : '1;
		md = (pkt_is_mpls && !pkt_is_ipv4) ? 128'hF_FFFF : ms;
		return x[377 + pkt_ingress_port]
			&& fh(x, (pkt_src_ip & ms) == (x[127:0] & ms), 290)
			&& fh(x, (pkt_dst_ip & md) == (x[255:128] & md), 292)
			&& ((pkt_tcp_flags ^ x[273:265]) & x[264:256]) == 9'h0
			&& ((pkt_options_byte ^ x[289:282]) & x[281:274]) == 8'h0
			&& fh(x, pkt_chain_present == x[296], 294)
			&& fh(x, pkt_src_l4_port == x[314:299], 297)
			&& fh(x, pkt_dst_l4_port == x[332:317], 315)
			&& fh(x, pkt_service_type == x[342:335], 333)
			&& fh(x, pkt_payload_type == x[352:345], 343)
			&& fh(x, pkt_is_ipv4 == x[355], 353);
	endfunction : hit

	// bready and rready stay high, so responses are taken at once
	task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d,
		input logic [1:0] rsp);
		qb.push_back({30'h0, rsp, 32'h0});
		awaddr <= {i, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
	endtask : wr

	task automatic rd(input logic [IDX_W-1:0] i, input logic [33:0] e);
		qb.push_back({30'h0, e});
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
	endtask : rd

	// small value pools so that equal and unequal both happen often
	task automatic send();
		logic [63:0] r;
		logic        dsc;
		r = {$random(seed), $random(seed)};
		pkt_src_ip <= {$random(seed), $random(seed), $random(seed), 31'h0,
			r[0]};
		pkt_dst_ip <= {$random(seed), $random(seed), $random(seed), r[63:52],
			19'h0, r[1]};
		{pkt_is_ipv4, pkt_is_mpls, pkt_chain_present} <= r[4:2];
		pkt_src_l4_port <= {15'h0, r[5]};
		pkt_dst_l4_port <= {15'h0, r[6]};
		pkt_service_type <= {7'h0, r[7]};
		pkt_payload_type <= {7'h0, r[8]};
		pkt_tcp_flags <= r[17:9];
		pkt_options_byte <= r[25:18];
		pkt_ingress_port <= r[29:26];
		pkt_valid <= 1'b1;
		do
			@(posedge clock);
		while (pkt_ready !== 1'b1);
		dsc = 1'b0;
		lasthit = 32'h0;
		for (int e = 0; e < 32; e++)
			if (hit(ent[e]))
			begin
				qp.push_back(64'(e));
				lasthit[e] = 1'b1;
				dsc |= dmap[e];
			end
		qp.push_back(64'h100 | 64'(dsc));
		ndrop += dsc;
	endtask : send

	// ********
	// clock, watchdog, result monitor, main sequence
	// ********
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// whole run needs about 5000 cycles; the limit leaves ample room
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			summarize();
		end
	end

	// takes the oldest note whenever a result shows at the ports
	always @(posedge clock)
	begin
		if (bvalid === 1'b1)
			chk({30'h0, bresp, 32'h0}, pop(qb));
		if (rvalid === 1'b1)
			chk({30'h0, rresp, rdata}, pop(qb));
		if ((act_valid && act_ready) === 1'b1)
			chk(64'(act_index), pop(qp));
		if (pkt_done === 1'b1)
			chk(64'h100 | 64'(pkt_discard), pop(qp));
	end

	initial
	begin
		{srst, ce, bready, rready} = 4'hF;
		{awvalid, wvalid, arvalid, pkt_valid} = 4'h0;
		{awaddr, araddr, wdata, dmap, lasthit} = '0;
		wstrb = 4'hF;
		{pkt_src_ip, pkt_dst_ip, pkt_is_ipv4, pkt_is_mpls} = '0;
		{pkt_chain_present, pkt_src_l4_port, pkt_dst_l4_port} = '0;
		{pkt_tcp_flags, pkt_options_byte, pkt_ingress_port} = '0;
		{pkt_service_type, pkt_payload_type} = '0;
		rv = '0;
		foreach (sense_bits[k])
			rv[sense_bits[k]] = 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 512; i++)
			rd(BASE + 18'(i), {2'h0, rv[i % 16 * 32 +: 32]});
		rd(BASE + 18'h200, {RESP_SLVERR, 32'h0});
		wr(BASE + 18'h200, 32'hFFFF_FFFF, RESP_SLVERR);
		// random rules; unused value bits cleared to raise the hit rate
		keep = (512'h1 << 389) - 512'h1;
		{keep[31:1], keep[147:129], keep[264:258], keep[281:276]} = '0;
		{keep[314:300], keep[332:318], keep[342:336], keep[352:346]} = '0;
		for (int e = 0; e < 32; e++)
			for (int w = 0; w < 16; w++)
				ent[e][w * 32 +: 32] = $random(seed) & keep[w * 32 +: 32];
		ent[31] = rv | (512'hFFF << 377);
		dmap = $random(seed);
		for (int i = 0; i < 512; i++)
			wr(BASE + 18'(i), ent[i / 16][i % 16 * 32 +: 32], RESP_OKAY);
		for (int i = 0; i < 512; i++)
			rd(BASE + 18'(i), {2'h0, ent[i / 16][i % 16 * 32 +: 32]});
		repeat (300) send();
		pkt_valid <= 1'b0;
		while (qp.size() != 0) @(posedge clock);
		repeat (3) @(posedge clock);
		chk(64'(drop_count), 64'(ndrop));
		rd(DROP_COUNT_IDX, {2'h0, 32'(ndrop)});
		rd(LAST_HITS_IDX, {2'h0, lasthit});
		wr(DROP_COUNT_IDX, 32'h0, RESP_OKAY);
		rd(DROP_COUNT_IDX, 34'h0);
		repeat (2) @(posedge clock);
		summarize();
	end

endmodule : testbench

`default_nettype wire
